// ---- design/sfwp_guard_top.sv ----
// sfwp_guard_top: serial frame decode, mode control, write latch,
// region guard and per-unit locks of a serial flash
// assumes a host drives select and serial clock well below sys_clk / 4
`timescale 1ns/1ns
module sfwp_guard_top
	import sfwp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// serial link pins
	input  wire logic        sclkPin,
	input  wire logic        selectPin_n,
	input  wire logic        resetPin_n,
	input  wire logic [3:0]  ioIn,
	output logic      [3:0]  ioOut,
	output logic      [3:0]  ioOe,
	// configuration
	input  wire logic        guardSchemeSelect,
	// status and mode
	output logic             writeLatchFlag,
	output logic             fourWireCommandMode,
	output logic             deepPowerDown,
	output logic      [4:0]  regionGuardBits,
	output logic             statusLockBit,
	output logic             quadLinesActive,
	// array requests
	output logic             pageWriteGo,
	output logic             wipeGo,
	output logic             chipWipeGo,
	output logic             cmdRefused,
	output logic      [25:0] targetAddr
);
	////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic [1:0] rstPipe_reg;
	logic       rstSync_n;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			rstPipe_reg <= 2'h0;
		else
			rstPipe_reg <= {rstPipe_reg[0], 1'h1};
	end
	assign rstSync_n = rstPipe_reg[1];

	sfwp_pins_t pinsRaw;
	sfwp_pins_t pinsSync;
	assign pinsRaw = '{sclk: sclkPin, csN: selectPin_n,
		resetN: resetPin_n, io: ioIn};
	sfwp_pin_sync u_sync (
		.clk     (sys_clk),
		.rst_n   (rstSync_n),
		.pinsIn  (pinsRaw),
		.pinsOut (pinsSync)
	);

	////////////////////////////////////////////////////////////////////
	// edge detection on the sampled serial clock and select
	logic sclkPrev_reg;
	logic sclkRise;
	logic sclkFall;
	logic selActive;
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			sclkPrev_reg <= 1'h0;
		else
			sclkPrev_reg <= pinsSync.sclk;
	end
	// rise samples, fall drives; idle level of clock is irrelevant
	assign sclkRise = pinsSync.sclk & ~sclkPrev_reg;
	assign sclkFall = ~pinsSync.sclk & sclkPrev_reg;
	// a floating select would start frames; host holds it high
	assign selActive = ~pinsSync.csN;

	////////////////////////////////////////////////////////////////////
	// reset pin: low for the minimum pulse clears volatile state
	logic [7:0] pinLowCnt_reg;
	logic [7:0] pinLowCnt_next;
	logic       pinInReset;
	assign pinLowCnt_next = pinsSync.resetN ? 8'h00 :
		(pinLowCnt_reg == RESET_PULSE_CYC) ? pinLowCnt_reg :
		pinLowCnt_reg + 8'h01;
	assign pinInReset = ~pinsSync.resetN &&
		pinLowCnt_reg >= RESET_PULSE_CYC - 8'h01;
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			pinLowCnt_reg <= 8'h00;
		else
			pinLowCnt_reg <= pinLowCnt_next;
	end

	////////////////////////////////////////////////////////////////////
	// frame shifter
	sfwp_state_t state_reg;
	sfwp_state_t state_next;
	sfwp_cmd_t   cmd_reg;
	sfwp_cmd_t   cmd_next;
	logic [31:0] shift_reg;
	logic [31:0] shiftNext;
	logic [5:0]  bitCnt_reg;
	logic [5:0]  bitCnt_next;
	logic [5:0]  cntNext;
	logic        fourWire_reg;
	logic        wide;
	logic        dtrEdge;
	logic        shiftNow;
	logic        inOpcode;
	logic        inAddr;
	logic        inData;
	logic        volatileClr;

	assign inOpcode = state_reg == ST_OPCODE;
	assign inAddr = state_reg == ST_ADDR;
	assign inData = state_reg == ST_DATA;
	// four-wire opcode; quad address and data phases
	assign wide = inOpcode ? fourWire_reg :
		inAddr ? (fourWire_reg | quadAddr(cmd_reg.opcode)) :
		(fourWire_reg | quadData(cmd_reg.opcode));
	assign dtrEdge = isDtr(cmd_reg.opcode) & inAddr & sclkFall;
	assign shiftNow = selActive & (sclkRise | dtrEdge) &
		(inOpcode | inAddr | inData);
	assign shiftNext = wide ? {shift_reg[27:0], pinsSync.io} :
		{shift_reg[30:0], pinsSync.io[0]};
	assign cntNext = bitCnt_reg + (wide ? 6'h04 : 6'h01);

	// next frame state; a long read just keeps counting data bytes
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		bitCnt_next = bitCnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (selActive && !volatileClr) begin
					state_next = ST_OPCODE;
					cmd_next = '0;
					bitCnt_next = 6'h00;
				end
			end
			ST_OPCODE: begin
				if (shiftNow) begin
					bitCnt_next = cntNext;
					if (cntNext == OPC_BITS) begin
						cmd_next.opcode = shiftNext[7:0];
						cmd_next.opDone = 1'h1;
						bitCnt_next = 6'h00;
						state_next = hasAddr(shiftNext[7:0]) ?
							ST_ADDR : ST_DATA;
					end
				end
			end
			ST_ADDR: begin
				if (shiftNow) begin
					bitCnt_next = cntNext;
					if (cntNext == ADR_BITS) begin
						cmd_next.addr = shiftNext[25:0];
						cmd_next.addrDone = 1'h1;
						bitCnt_next = 6'h00;
						state_next = (cmd_reg.opcode == OP_LOCK_RD) ?
							ST_OUT : ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (shiftNow) begin
					bitCnt_next = cntNext;
					if (cntNext == DAT_BITS) begin
						bitCnt_next = 6'h00;
						if (!cmd_reg.dataDone)
							cmd_next.data = shiftNext[7:0];
						cmd_next.dataDone = 1'h1;
					end
				end
			end
			ST_OUT: begin
				state_next = ST_OUT;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (state_reg != ST_IDLE && (!selActive || volatileClr))
			state_next = ST_IDLE;
	end

	// frame registers
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
			bitCnt_reg <= 6'h00;
			shift_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shiftNow ? shiftNext : shift_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// command execution, one cycle after select rises
	logic       execPending_reg;
	logic [7:0] op;
	logic       exec;
	logic       live;
	logic       lockRd;
	logic       anyLock;
	logic       unitHit;
	logic       anyGuard;
	logic       hwLocked;
	logic       refuse;
	logic       accept;
	logic       softReset;
	logic       wel_reg;
	logic       dpd_reg;
	logic       arm_reg;
	logic [4:0] guard_reg;
	logic       statusLock_reg;

	assign op = cmd_reg.opcode;
	assign exec = execPending_reg & cmd_reg.opDone & ~pinInReset;
	// only wake and the reset pair pass while asleep
	assign live = exec & (~dpd_reg | op == OP_WAKE |
		op == OP_RST_ARM | op == OP_RST_GO);
	assign softReset = live & op == OP_RST_GO & arm_reg;
	assign volatileClr = softReset | pinInReset;
	// scheme select picks guard bits or unit locks
	assign unitHit = guardSchemeSelect ?
		guardHit(guard_reg, cmd_reg.addr) : lockRd;
	assign anyGuard = guardSchemeSelect ?
		(guard_reg[3:0] != 4'h0) : anyLock;
	// protect pin is io2 only outside four-wire mode
	assign hwLocked = statusLock_reg & ~fourWire_reg & ~pinsSync.io[2];
	assign refuse = live & isMod(op) & (~wel_reg |
		((isPageWr(op) | isWipe(op)) & (unitHit | ~cmd_reg.addrDone)) |
		(isChipWipe(op) & anyGuard) |
		(op == OP_STATUS_WR & (hwLocked | ~cmd_reg.dataDone)));
	assign accept = live & isMod(op) & ~refuse;

	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			execPending_reg <= 1'h0;
		else
			execPending_reg <= state_reg != ST_IDLE && !selActive;
	end

	// write latch; one command per frame, no set/clear clash
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			wel_reg <= 1'h0;
		else if (volatileClr)
			wel_reg <= 1'h0;
		else if (live && op == OP_LATCH_SET)
			wel_reg <= 1'h1;
		else if (live && (op == OP_LATCH_CLR || isMod(op)))
			wel_reg <= 1'h0;
	end

	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			fourWire_reg <= 1'h0;
			dpd_reg <= 1'h0;
			arm_reg <= 1'h0;
		end else if (volatileClr) begin
			fourWire_reg <= 1'h0;
			dpd_reg <= 1'h0;
			arm_reg <= 1'h0;
		end else if (live) begin
			fourWire_reg <= (op == OP_FOUR_ON) ? 1'h1 :
				(op == OP_FOUR_OFF) ? 1'h0 : fourWire_reg;
			dpd_reg <= (op == OP_SLEEP) ? 1'h1 :
				(op == OP_WAKE) ? 1'h0 : dpd_reg;
			arm_reg <= op == OP_RST_ARM;
		end
	end

	// guard bits survive soft and pin resets
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			guard_reg <= GUARD_RST;
			statusLock_reg <= STATUS_LOCK_RST;
		end else if (accept && op == OP_STATUS_WR) begin
			guard_reg <= cmd_reg.data[6:2];
			statusLock_reg <= cmd_reg.data[7];
		end
	end

	////////////////////////////////////////////////////////////////////
	// unit locks
	sfwp_lock_mem u_locks (
		.clk      (sys_clk),
		.rst_n    (rstSync_n),
		.setAll   (live && op == OP_LOCK_ALL),
		.clearAll (volatileClr || (live && op == OP_UNLOCK_ALL)),
		.write_latch_set_cmd     (live && cmd_reg.addrDone &&
			(op == OP_LOCK || op == OP_UNLOCK)),
		.wrVal    (op == OP_LOCK),
		.wrIdx    (lockIndex(cmd_reg.addr)),
		.rdIdx    (lockIndex(cmd_reg.addr)),
		.rdData   (lockRd),
		.anySet   (anyLock)
	);

	////////////////////////////////////////////////////////////////////
	// outputs: pulses, lock read-back drive, quad flag
	logic [3:0]  ioOut_reg;
	logic [3:0]  ioOe_reg;
	logic        quad_reg;
	logic        pageGo_reg;
	logic        wipeGo_reg;
	logic        chipGo_reg;
	logic        refused_reg;
	logic [25:0] target_reg;
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ioOut_reg <= 4'h0;
			ioOe_reg <= 4'h0;
		end else if (state_reg != ST_OUT || !selActive) begin
			ioOe_reg <= 4'h0;
		end else if (sclkFall) begin
			// lock state changes after the falling edge
			ioOut_reg <= fourWire_reg ? {4{lockRd}} : {2'h0, lockRd, 1'h0};
			ioOe_reg <= fourWire_reg ? 4'hF : 4'h2;
		end
	end
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			quad_reg <= 1'h0;
			pageGo_reg <= 1'h0;
			wipeGo_reg <= 1'h0;
			chipGo_reg <= 1'h0;
			refused_reg <= 1'h0;
			target_reg <= 26'h0;
		end else begin
			// tells the data path to use four lines
			quad_reg <= inData & selActive & (fourWire_reg | quadData(op));
			pageGo_reg <= accept & isPageWr(op);
			wipeGo_reg <= accept & isWipe(op);
			chipGo_reg <= accept & isChipWipe(op);
			refused_reg <= refuse;
			target_reg <= accept ? cmd_reg.addr : target_reg;
		end
	end
	assign ioOut = ioOut_reg;
	assign ioOe = ioOe_reg;
	assign writeLatchFlag = wel_reg;
	assign fourWireCommandMode = fourWire_reg;
	assign deepPowerDown = dpd_reg;
	assign regionGuardBits = guard_reg;
	assign statusLockBit = statusLock_reg;
	assign quadLinesActive = quad_reg;
	assign pageWriteGo = pageGo_reg;
	assign wipeGo = wipeGo_reg;
	assign chipWipeGo = chipGo_reg;
	assign cmdRefused = refused_reg;
	assign targetAddr = target_reg;

	////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstSync_n);

	sequence sArmed;
		arm_reg && live && op == OP_RST_GO;
	endsequence
	sequence sSingleClean;
		!fourWire_reg && !wel_reg && !arm_reg;
	endsequence
	sequence sLatchCmd;
		live && op == OP_LATCH_SET && !volatileClr;
	endsequence

	a_latch_set_cmd: assert property (
		sLatchCmd |=> wel_reg ##1 wel_reg || exec)
		else $error("latch not set by set command");
	a_latch_clear_ops: assert property (
		live && (op == OP_LATCH_CLR || isMod(op)) |=> !wel_reg)
		else $error("latch not cleared");
	a_mode_enter: assert property (
		live && op == OP_FOUR_ON && !volatileClr |=> fourWire_reg)
		else $error("four-wire mode not entered");
	a_mode_exit: assert property (
		live && op == OP_FOUR_OFF |=> !fourWire_reg)
		else $error("four-wire mode not left");
	a_soft_reset_pair: assert property (
		sArmed |=> sSingleClean)
		else $error("reset pair left volatile state");
	a_no_latch_write: assert property (
		pageWriteGo || wipeGo || chipWipeGo |-> $past(wel_reg))
		else $error("write issued without latch");
	a_guard_refuse: assert property (
		live && isPageWr(op) && guardSchemeSelect &&
		guardHit(guard_reg, cmd_reg.addr) |=> cmdRefused && !pageWriteGo)
		else $error("program into guarded region");
	a_chip_clean: assert property (
		chipWipeGo |-> $past(!anyGuard))
		else $error("chip wipe with protection set");
	a_status_locked: assert property (
		live && op == OP_STATUS_WR && hwLocked |=> $stable(guard_reg)
		&& $stable(statusLock_reg))
		else $error("locked status was written");
	a_sleep_ignore: assert property (
		exec && dpd_reg && op == OP_LATCH_SET && !volatileClr
		|=> wel_reg == $past(wel_reg))
		else $error("command obeyed in deep power-down");
	a_pin_reset: assert property (
		pinInReset |=> !wel_reg && !fourWire_reg && !dpd_reg
		&& state_reg == ST_IDLE)
		else $error("pin reset left volatile state");
	a_wide_opcode: assert property (
		shiftNow && inOpcode && fourWire_reg && bitCnt_reg == 6'h00
		|=> bitCnt_reg == 6'h04)
		else $error("four-wire opcode not four bits a clock");
endmodule

// ---- design/sfwp_lock_mem.sv ----
// sfwp_lock_mem: volatile lock bits, one per protected unit
// assumes one write source; bulk clear beats bulk set beats one write
`timescale 1ns/1ns
module sfwp_lock_mem
	import sfwp_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// bulk control
	input  wire logic                  setAll,
	input  wire logic                  clearAll,
	// single unit write
	input  wire logic                  write_latch_set_cmd,
	input  wire logic                  wrVal,
	input  wire logic [LOCK_IDX_W-1:0] wrIdx,
	// registered read
	input  wire logic [LOCK_IDX_W-1:0] rdIdx,
	output logic                       rdData,
	output logic                       anySet
);
	logic [LOCK_UNITS-1:0] bits_reg;
	logic                  rdData_reg;
	logic                  anySet_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bits_reg <= '0;
		else if (clearAll)
			bits_reg <= '0;
		else if (setAll)
			bits_reg <= '1;
		else if (write_latch_set_cmd && wrIdx < LOCK_UNITS)
			bits_reg[wrIdx] <= wrVal;
	end
	// read costs one cycle; callers hold the index steady
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 1'h0;
			anySet_reg <= 1'h0;
		end else begin
			rdData_reg <= (rdIdx < LOCK_UNITS) ? bits_reg[rdIdx] : 1'h0;
			anySet_reg <= |bits_reg;
		end
	end
	assign rdData = rdData_reg;
	assign anySet = anySet_reg;
endmodule

// ---- design/sfwp_pin_sync.sv ----
// sfwp_pin_sync: two-stage synchroniser for the serial pins
// assumes pins are asynchronous to clk; only stage two is read
`timescale 1ns/1ns
module sfwp_pin_sync
	import sfwp_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// pins
	input  wire sfwp_pins_t pinsIn,
	output sfwp_pins_t      pinsOut
);
	sfwp_pins_t stage1_reg;
	sfwp_pins_t stage2_reg;
	// idle levels: select and reset pin high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= '{sclk: 1'h0, csN: 1'h1, resetN: 1'h1, io: 4'hF};
			stage2_reg <= '{sclk: 1'h0, csN: 1'h1, resetN: 1'h1, io: 4'hF};
		end else begin
			stage1_reg <= pinsIn;
			stage2_reg <= stage1_reg;
		end
	end
	assign pinsOut = stage2_reg;
endmodule

// ---- design/sfwp_pkg.sv ----
// sfwp_pkg: opcodes, sizes, carriers and decode functions of the
// serial flash mode and write-protect block
// assumes one 20 MHz system clock; every pin arrives unsynchronised
// Functional notes
// - modes 0 and 3; rise samples, fall drives
// - quad opcodes move four bits per clock
// - both-edge quad read shifts on both edges; code shifts on both edges in the address phase only, data on rise
// - 38h enters, FFh leaves four-wire mode
// - four-wire mode sends opcode on four lines
// - power-up and 66h then 99h: single mode
// - long reset pin low restores volatile defaults
// - latch set command sets write latch flag
// - latch clears on reset, disable, writes, erases
// - guard bits pick a read-only region
// - low bits zero: none; top clear: upper
// - top bit set protects upward from zero
// - bits three and two, or 1011: all
// - status lock with low protect pin locks; code reads the protect pin on io2 outside four-wire mode only
// - deep power-down ignores all but wake, reset; code still drives the 3Dh lock read-back on io while asleep
// - 36h locks, 39h unlocks, 3Dh reads lock
// - 7Eh locks all, 98h unlocks all
// - lock bits volatile, clear on reset
// - edge blocks lock per 4KB sector
// - scheme select zero picks per-block locks
// - 256B pages, 4K sectors, 64K blocks
// - clear latch rejects writes, programs, erases
// - guarded region refuses program and wipes
// - chip wipe only with nothing protected
package sfwp_pkg;
	// timing
	localparam int unsigned SYS_CLK_HZ = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	localparam int unsigned RESET_PULSE_MIN_NS = 1000;
	localparam int unsigned RESET_PULSE_CYC_I =
		(RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RESET_PULSE_CYC =
		8'(RESET_PULSE_CYC_I < 1 ? 1 : RESET_PULSE_CYC_I);
	// array geometry, lock units: 16 + 16 edge sectors, 1022 blocks
	localparam int unsigned LOCK_UNITS = 1054;
	localparam int unsigned LOCK_IDX_W = 11;
	localparam logic [10:0] LOCK_MID_OFS = 11'h01F;
	// frame phase lengths in bits, address is four bytes
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADR_BITS = 6'h20;
	localparam logic [5:0] DAT_BITS = 6'h08;
	// values after reset
	localparam logic [4:0] GUARD_RST = 5'h00;
	localparam logic STATUS_LOCK_RST = 1'h0;
	// opcodes
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_STATUS_WR = 8'h01;
	localparam logic [7:0] OP_UPADDR_WR = 8'hC5;
	localparam logic [7:0] OP_PCFG_WR = 8'hB1;
	localparam logic [7:0] OP_TCFG_WR = 8'h81;
	localparam logic [7:0] OP_PAGE_WR = 8'h02;
	localparam logic [7:0] OP_QPAGE_WR = 8'h32;
	localparam logic [7:0] OP_QPAGE_WR4 = 8'h34;
	localparam logic [7:0] OP_SECT_WIPE = 8'h20;
	localparam logic [7:0] OP_BLK_WIPE = 8'hD8;
	localparam logic [7:0] OP_BLK32_WIPE = 8'h52;
	localparam logic [7:0] OP_CHIP_WIPE = 8'hC7;
	localparam logic [7:0] OP_CHIP_WIPE2 = 8'h60;
	localparam logic [7:0] OP_SEC_WIPE = 8'h44;
	localparam logic [7:0] OP_SEC_WR = 8'h42;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RST_GO = 8'h99;
	localparam logic [7:0] OP_FOUR_ON = 8'h38;
	localparam logic [7:0] OP_FOUR_OFF = 8'hFF;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_LOCK_RD = 8'h3D;
	localparam logic [7:0] OP_LOCK_ALL = 8'h7E;
	localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
	localparam logic [7:0] OP_QOUT_RD = 8'h6B;
	localparam logic [7:0] OP_QOUT_RD4 = 8'h6C;
	localparam logic [7:0] OP_QIO_RD = 8'hEB;
	localparam logic [7:0] OP_QIO_RD4 = 8'hEC;
	localparam logic [7:0] OP_DTR_RD = 8'hED;
	localparam logic [7:0] OP_DTR_RD4 = 8'hEE;
	// frame states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_OPCODE = 5'b00010,
		ST_ADDR = 5'b00100,
		ST_DATA = 5'b01000,
		ST_OUT = 5'b10000
	} sfwp_state_t;
	// pins as one bundle for the synchroniser
	typedef struct packed {
		logic sclk;
		logic csN;
		logic resetN;
		logic [3:0] io;
	} sfwp_pins_t;
	// one received command
	typedef struct packed {
		logic [7:0] opcode;
		logic [25:0] addr;
		logic [7:0] data;
		logic opDone;
		logic addrDone;
		logic dataDone;
	} sfwp_cmd_t;
	function automatic logic isPageWr(input logic [7:0] op);
		isPageWr = op == OP_PAGE_WR || op == OP_QPAGE_WR ||
			op == OP_QPAGE_WR4;
	endfunction
	function automatic logic isWipe(input logic [7:0] op);
		isWipe = op == OP_SECT_WIPE || op == OP_BLK_WIPE ||
			op == OP_BLK32_WIPE;
	endfunction
	function automatic logic isChipWipe(input logic [7:0] op);
		isChipWipe = op == OP_CHIP_WIPE || op == OP_CHIP_WIPE2;
	endfunction
	function automatic logic isMod(input logic [7:0] op);
		isMod = isPageWr(op) || isWipe(op) || isChipWipe(op) ||
			op == OP_STATUS_WR || op == OP_UPADDR_WR ||
			op == OP_PCFG_WR || op == OP_TCFG_WR ||
			op == OP_SEC_WIPE || op == OP_SEC_WR;
	endfunction
	function automatic logic isDtr(input logic [7:0] op);
		isDtr = op == OP_DTR_RD || op == OP_DTR_RD4;
	endfunction
	function automatic logic quadAddr(input logic [7:0] op);
		quadAddr = op == OP_QIO_RD || op == OP_QIO_RD4 || isDtr(op);
	endfunction
	function automatic logic quadData(input logic [7:0] op);
		quadData = op == OP_QPAGE_WR || op == OP_QPAGE_WR4 ||
			op == OP_QOUT_RD || op == OP_QOUT_RD4 || quadAddr(op);
	endfunction
	function automatic logic hasAddr(input logic [7:0] op);
		hasAddr = isPageWr(op) || isWipe(op) || quadData(op) ||
			op == OP_LOCK || op == OP_UNLOCK || op == OP_LOCK_RD ||
			op == OP_SEC_WIPE || op == OP_SEC_WR;
	endfunction
	// region decode; span doubles per code step
	function automatic logic guardHit(input logic [4:0] g,
			input logic [25:0] a);
		logic [10:0] span;
		logic [9:0] blk;
		blk = a[25:16];
		span = 11'h001 << (g[3:0] - 4'h1);
		if (g[3:0] == 4'h0)
			guardHit = 1'h0;
		else if ((g[3] && g[2]) || g[3:0] == 4'hB)
			guardHit = 1'h1;
		else if (g[4])
			guardHit = {1'h0, blk} < span;
		else
			guardHit = {1'h0, ~blk} < span;
	endfunction
	// sector split; edge sectors are units 0..31
	function automatic logic [10:0] lockIndex(input logic [25:0] a);
		logic [9:0] blk;
		blk = a[25:16];
		if (blk == 10'h000)
			lockIndex = {7'h00, a[15:12]};
		else if (blk == 10'h3FF)
			lockIndex = {7'h01, a[15:12]};
		else
			lockIndex = 11'({1'h0, blk} + LOCK_MID_OFS);
	endfunction
endpackage

// ---- tb/sfwp_host_model.sv ----
// sfwp_host_model: host side of the serial link
// assumes pulled-up io lines; serial clock period 400 ns
`timescale 1ns/1ns
module sfwp_host_model (
	// clock
	input  wire logic sys_clk,
	// link pins
	output logic      sclkPin,
	output logic      selectPin_n,
	output logic [3:0] ioIn
);
	logic cpol = 1'h0; // idle clock level, mode 0 or 3
	logic wp = 1'h1; // protect pin level on io2
	initial begin
		sclkPin = 1'h0;
		selectPin_n = 1'h1;
		ioIn = 4'hF;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// change after fall, device samples on rise
	// four lines per edge in four-wire mode
	task automatic frame(input logic [47:0] v, input int n, input int w);
		selectPin_n <= 1'h0;
		for (int i = 0; i < n; i += w) begin
			hw(4);
			sclkPin <= 1'h0;
			ioIn <= w == 4 ? v[47:44] : {1'h1, wp, 1'h1, v[47]};
			v = v << w;
			hw(4);
			sclkPin <= 1'h1;
		end
		hw(4);
		sclkPin <= cpol;
		ioIn <= {1'h1, wp, 2'h3}; // released lines float up
		hw(4);
		selectPin_n <= 1'h1;
		hw(10);
	endtask
endmodule

// ---- tb/tb.sv ----
// tb: self-checking bench of the mode and guard block
// assumes the host model paces every frame
`timescale 1ns/1ns
module tb;
	import sfwp_pkg::*;
	logic sys_clk = 1'h0, reset_n = 1'h0, resetPin_n = 1'h1, scheme = 1'h1;
	logic sclk, selN, wl, fw, dpd, pg, rf, sl, wg, cg, qa;
	logic [3:0] io, ido, ioe;
	bit qSeen;
	bit [3:0] oeSeen;
	logic [4:0] gb;
	logic [25:0] ta;
	int failCount = 0, checkCount = 0, goCnt = 0, refCnt = 0;
	int wipeCnt = 0, chipCnt = 0;
	sfwp_host_model u_sfwp_host_model (.sys_clk(sys_clk), .sclkPin(sclk),
		.selectPin_n(selN), .ioIn(io));
	sfwp_guard_top u_sfwp_guard_top (.sys_clk(sys_clk), .reset_n(reset_n),
		.sclkPin(sclk), .selectPin_n(selN), .resetPin_n(resetPin_n),
		.ioIn(io), .ioOut(ido), .ioOe(ioe), .guardSchemeSelect(scheme),
		.writeLatchFlag(wl), .fourWireCommandMode(fw),
		.deepPowerDown(dpd), .regionGuardBits(gb), .statusLockBit(sl),
		.quadLinesActive(qa), .pageWriteGo(pg), .wipeGo(wg),
		.chipWipeGo(cg), .cmdRefused(rf), .targetAddr(ta));
	// 50 ns system clock
	initial forever #25 sys_clk = ~sys_clk;
	// pulse tallies, one-cycle pulses are easy to miss otherwise
	always @(posedge sys_clk) begin
		goCnt <= goCnt + pg;
		refCnt <= refCnt + rf;
		wipeCnt <= wipeCnt + wg;
		chipCnt <= chipCnt + cg;
		qSeen <= qSeen | qa;
		oeSeen <= oeSeen | ioe;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] a,
			input logic [7:0] d, input int n, input int w = 1);
		u_sfwp_host_model.frame({op, a, d}, n, w);
	endtask
	// latch set, then one page write; ok says accepted or refused
	task automatic pw(input logic [31:0] a, input logic ok);
		int g, r;
		g = goCnt;
		r = refCnt;
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_PAGE_WR, a, 8'h5A, 48);
		chk(goCnt - g, ok);
		chk(refCnt - r, !ok);
		chk(wl, 1'h0);
		if (ok) chk(ta, a[25:0]);
	endtask
	task automatic tLatch;
		chk(fw, 1'h0);
		cmd(OP_PAGE_WR, 32'h100, 8'h00, 48);
		chk(refCnt, 1);
		chk(qSeen, 1'h0);
		cmd(OP_QPAGE_WR, 32'h100, 8'h00, 48);
		chk(qSeen, 1'h1);
		chk(refCnt, 2);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		chk(wl, 1'h1);
		cmd(OP_LATCH_CLR, 32'h0, 8'h00, 8);
		chk(wl, 1'h0);
	endtask
	// guard codes: upper, lower, all, top bit ignored when low bits zero
	task automatic tGuard;
		logic [4:0] g[7] = '{5'h01, 5'h01, 5'h12, 5'h12, 5'h0B, 5'h1C, 5'h10};
		logic [31:0] a[7] = '{32'h3FF0000, 32'h3FEFFFF, 32'h1FFFF,
			32'h20000, 32'h0, 32'h2000000, 32'h0};
		logic [6:0] ok = 7'h4A;
		for (int i = 0; i < 7; i++) begin
			cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
			cmd(OP_STATUS_WR, {1'h0, g[i], 2'h0, 24'h0}, 8'h00, 16);
			chk(gb, g[i]);
			pw(a[i], ok[i]);
		end
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_CHIP_WIPE, 32'h0, 8'h00, 8);
		chk(chipCnt, 1);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_SECT_WIPE, 32'h3FF0000, 8'h00, 40);
		chk(wipeCnt, 1);
		chk(ta, 26'h3FF0000);
		// status lock set, then a low protect pin refuses the write
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_STATUS_WR, 32'h80000000, 8'h00, 16);
		chk(sl, 1'h1);
		u_sfwp_host_model.wp = 1'h0;
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_STATUS_WR, 32'h04000000, 8'h00, 16);
		chk(gb, 5'h00);
		u_sfwp_host_model.wp = 1'h1;
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_STATUS_WR, 32'h0, 8'h00, 16);
		chk(sl, 1'h0);
	endtask
	task automatic tMode;
		cmd(OP_FOUR_ON, 32'h0, 8'h00, 8);
		chk(fw, 1'h1);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8, 4);
		chk(wl, 1'h1);
		cmd(OP_RST_ARM, 32'h0, 8'h00, 8, 4);
		cmd(OP_RST_GO, 32'h0, 8'h00, 8, 4);
		chk(fw, 1'h0);
		cmd(OP_FOUR_ON, 32'h0, 8'h00, 8);
		cmd(OP_FOUR_OFF, 32'h0, 8'h00, 8, 4);
		chk(fw, 1'h0);
	endtask
	task automatic tSleep;
		cmd(OP_SLEEP, 32'h0, 8'h00, 8);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		chk({dpd, wl}, 2'h2);
		cmd(OP_WAKE, 32'h0, 8'h00, 8);
		chk(dpd, 1'h0);
	endtask
	// unit locks in mode 3, then a pin reset drops them
	task automatic tLock;
		u_sfwp_host_model.cpol = 1'h1;
		scheme <= 1'h0;
		cmd(OP_LOCK, 32'h1000, 8'h00, 40);
		cmd(OP_LOCK_RD, 32'h1000, 8'h00, 48);
		chk({ido, ioe, oeSeen}, 12'h202);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		cmd(OP_CHIP_WIPE, 32'h0, 8'h00, 8);
		chk(chipCnt, 1);
		pw(32'h1FFF, 1'h0);
		pw(32'h2000, 1'h1);
		cmd(OP_LOCK_ALL, 32'h0, 8'h00, 8);
		pw(32'h500000, 1'h0);
		cmd(OP_UNLOCK_ALL, 32'h0, 8'h00, 8);
		pw(32'h1000, 1'h1);
		cmd(OP_LOCK, 32'h30000, 8'h00, 40);
		cmd(OP_UNLOCK, 32'h30000, 8'h00, 40);
		pw(32'h30000, 1'h1);
		cmd(OP_LOCK_ALL, 32'h0, 8'h00, 8);
		cmd(OP_LATCH_SET, 32'h0, 8'h00, 8);
		resetPin_n <= 1'h0;
		repeat (25) @(posedge sys_clk);
		resetPin_n <= 1'h1;
		repeat (6) @(posedge sys_clk);
		chk(wl, 1'h0);
		pw(32'h1000, 1'h1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// reset, then every scenario in turn
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'h1;
		repeat (6) @(posedge sys_clk);
		tLatch;
		tGuard;
		tMode;
		tSleep;
		tLock;
		conclude;
	end
endmodule
